// ---- rtl/srs_pkg.sv ----
package srs_pkg;

   // Geometry
   localparam int NUM_SER = 16;
   localparam int ADDR_W = 9;

   // Register byte offsets
   localparam logic [8:0] OFS_TX_DMA_CTL = 9'h0cc;
   localparam logic [8:0] OFS_SER_CTL_BASE = 9'h180;
   localparam logic [8:0] OFS_SER_CTL_LAST = 9'h1bc;
   localparam logic [8:0] OFS_EVT_STATUS = 9'h1c0;
   localparam logic [8:0] OFS_EVT_MASK = 9'h1c4;

   // Field positions
   localparam int BIT_DMA_EN = 0;
   localparam int BIT_MODE_LO = 0;
   localparam int BIT_DRIVE_LO = 2;
   localparam int BIT_TX_RDY = 4;
   localparam int BIT_RX_RDY = 5;
   localparam int CTL_USED_W = 6;
   localparam int UNDERRUN_LO = 16;

   // Serializer modes
   localparam logic [1:0] MODE_INACTIVE = 2'h0;
   localparam logic [1:0] MODE_TX = 2'h1;
   localparam logic [1:0] MODE_RX = 2'h2;

   // Idle pin drive modes
   localparam logic [1:0] DRIVE_TRI = 2'h0;
   localparam logic [1:0] DRIVE_LOW = 2'h2;
   localparam logic [1:0] DRIVE_HIGH = 2'h3;

   // Values after reset
   localparam logic RST_DMA_EN_BIT = 1'b0;
   localparam logic [3:0] RST_SER_CTL = 4'h0;
   localparam logic [31:0] RST_WORD = 32'h0;

   // Writable part of a serializer control word
   typedef struct packed {
      logic [1:0] drive;
      logic [1:0] mode;
   } srs_ser_ctl_t;

   // Per-serializer state and event pulses
   typedef struct packed {
      logic rx_ready;
      logic tx_ready;
      logic rx_overrun;
      logic tx_underrun;
   } srs_ser_stat_t;

endpackage : srs_pkg

// ---- rtl/srs_ser_ready.sv ----
`timescale 1ns/1ps
`default_nettype none
module srs_ser_ready
   import srs_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Configuration
   input wire logic [1:0] mode,
   input wire logic clear_level,
   input wire logic clear_rise,
   // Buffer events
   input wire logic rx_load,
   input wire logic rx_read,
   input wire logic tx_write,
   input wire logic slot_start,
   // State out
   output srs_ser_stat_t stat
);

   logic rx_rdy_reg, rx_rdy_next;
   logic tx_rdy_reg, tx_rdy_next;
   logic ovr_reg, ovr_next;
   logic und_reg, und_next;

   // Ready flags; a setting event wins over a clearing one
   always_comb begin
      rx_rdy_next = rx_rdy_reg;
      if (mode != MODE_RX) begin
         rx_rdy_next = 1'b0; // R05
      end else if (rx_load) begin
         rx_rdy_next = 1'b1; // R06
      end else if (rx_read) begin
         rx_rdy_next = 1'b0; // R13
      end
      tx_rdy_next = tx_rdy_reg;
      if (mode != MODE_TX) begin
         tx_rdy_next = 1'b0; // R08 R10
      end else if (clear_rise) begin
         tx_rdy_next = 1'b1; // R09
      end else if (!clear_level || tx_write) begin
         tx_rdy_next = 1'b0; // R10
      end
      // Slot boundary with buffer still unserviced
      ovr_next = (mode == MODE_RX) && slot_start && rx_rdy_reg && !rx_read; // R07
      und_next = (mode == MODE_TX) && clear_level && slot_start && tx_rdy_reg && !tx_write; // R11
   end

   // State registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rx_rdy_reg <= 1'b0;
         tx_rdy_reg <= 1'b0;
         ovr_reg <= 1'b0;
         und_reg <= 1'b0;
      end else begin
         rx_rdy_reg <= rx_rdy_next;
         tx_rdy_reg <= tx_rdy_next;
         ovr_reg <= ovr_next;
         und_reg <= und_next;
      end
   end

   assign stat = '{rx_ready: rx_rdy_reg, tx_ready: tx_rdy_reg, rx_overrun: ovr_reg, tx_underrun: und_reg};

endmodule : srs_ser_ready
`default_nettype wire

// ---- rtl/srs_serializer_ready_status.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// R01 - DMA request enable bit value 0 means transmit DMA requests are enabled.
// R02 - Software always writes 0 into the transmit DMA request enable bit.
// R03 - Reserved bits of DMA control and serializer control read 0, writes ignored.
// R04 - Sixteen serializer control words at consecutive word addresses 0x180 to 0x1bc.
// R05 - Receive ready bit 5 reads 0 when serializer is transmitter or inactive.
// R06 - In receive mode, receive ready sets whenever a word enters the receive buffer.
// R07 - Receive ready still set at next slot start registers a receiver overrun.
// R08 - Transmit ready bit 4 reads 0 when serializer is receiver or inactive.
// R09 - In transmit mode, transmit ready sets on rising edge of transmit clear control.
// R10 - Transmit ready holds until clear control drops, buffer written, or mode leaves transmit.
// R11 - Transmit ready still set at next slot start registers a transmit underrun.
// R12 - Idle pin drive: 0 high impedance, 2 low, 3 high, 1 reserved.
// R13 - Receive ready clears when the receive buffer is read.
module srs_serializer_ready_status
   import srs_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Global transmit control and slot timing
   input wire logic tx_serializer_clear,
   input wire logic slot_start,
   // Serializer buffer events
   input wire logic [NUM_SER-1:0] rx_word_load,
   input wire logic [NUM_SER-1:0] rx_buf_read,
   input wire logic [NUM_SER-1:0] tx_buf_write,
   input wire logic [NUM_SER-1:0] tx_inactive_slot,
   // Status towards the data path
   output logic tx_data_dma_request_enable,
   output logic [NUM_SER-1:0] rx_buffer_ready,
   output logic [NUM_SER-1:0] tx_buffer_ready,
   output logic [2*NUM_SER-1:0] serializer_mode,
   // Idle pin drive
   output logic [NUM_SER-1:0] pin_idle_out,
   output logic [NUM_SER-1:0] pin_idle_oe,
   // Interrupt
   output logic irq
);

   // Address in the serializer control range, word aligned
   function automatic logic ser_ctl_hit(input logic [ADDR_W-1:0] a);
      ser_ctl_hit = (a >= OFS_SER_CTL_BASE) && (a <= OFS_SER_CTL_LAST) && (a[1:0] == 2'h0);
   endfunction : ser_ctl_hit

   // Serializer number from a control address
   function automatic logic [3:0] ser_index(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] rel;
      rel = a - OFS_SER_CTL_BASE;
      ser_index = rel[5:2];
   endfunction : ser_index

   // Pin level and enable for one idle serializer
   function automatic logic [1:0] idle_drive(input logic idle, input logic [1:0] drv);
      idle_drive = 2'h0;
      if (idle) begin
         case (drv)
            DRIVE_LOW: idle_drive = 2'h2;
            DRIVE_HIGH: idle_drive = 2'h3;
            default: idle_drive = 2'h0;
         endcase
      end
   endfunction : idle_drive

   logic dma_bit_reg, dma_bit_next;
   srs_ser_ctl_t [NUM_SER-1:0] ctl_reg;
   srs_ser_ctl_t [NUM_SER-1:0] ctl_next;
   logic [31:0] status_reg, status_next;
   logic [31:0] mask_reg, mask_next;
   logic [31:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;
   logic dma_en_reg, dma_en_next;
   logic clear_prev_reg;
   logic clear_rise;
   logic [NUM_SER-1:0] pin_out_reg, pin_out_next;
   logic [NUM_SER-1:0] pin_oe_reg, pin_oe_next;
   srs_ser_stat_t [NUM_SER-1:0] stat;
   logic [31:0] events;
   logic [2*NUM_SER-1:0] mode_flat;

   // Rising edge of the global transmit clear control
   assign clear_rise = tx_serializer_clear && !clear_prev_reg; // R09

   // Per-serializer ready tracking
   genvar g;
   generate
      for (g = 0; g < NUM_SER; g++) begin : g_ser
         srs_ser_ready u_ready (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .mode(ctl_reg[g].mode),
            .clear_level(tx_serializer_clear),
            .clear_rise(clear_rise),
            .rx_load(rx_word_load[g]),
            .rx_read(rx_buf_read[g]),
            .tx_write(tx_buf_write[g]),
            .slot_start(slot_start),
            .stat(stat[g])
         );
         assign events[g] = stat[g].rx_overrun;
         assign events[UNDERRUN_LO+g] = stat[g].tx_underrun;
         assign rx_buffer_ready[g] = stat[g].rx_ready;
         assign tx_buffer_ready[g] = stat[g].tx_ready;
         assign mode_flat[2*g+1:2*g] = ctl_reg[g].mode;
      end
   endgenerate

   // Register writes, event capture and interrupt level
   always_comb begin
      dma_bit_next = dma_bit_reg;
      ctl_next = ctl_reg;
      mask_next = mask_reg;
      status_next = status_reg;
      if (reg_wr) begin
         if (reg_addr == OFS_TX_DMA_CTL) begin
            dma_bit_next = reg_wdata[BIT_DMA_EN]; // R03
         end
         if (ser_ctl_hit(reg_addr)) begin
            ctl_next[ser_index(reg_addr)] = reg_wdata[BIT_DRIVE_LO+1:BIT_MODE_LO]; // R04
         end
         if (reg_addr == OFS_EVT_MASK) begin
            mask_next = reg_wdata;
         end
         if (reg_addr == OFS_EVT_STATUS) begin
            status_next = status_reg & ~reg_wdata;
         end
      end
      // New events win over a clear in the same cycle
      status_next = status_next | events; // R07 R11
      irq_next = |(status_next & mask_next);
      // Bit value 0 is the enabled state
      dma_en_next = (dma_bit_next == 1'b0); // R01
   end

   // Read data, valid only in the cycle after the read strobe
   always_comb begin
      rdata_next = RST_WORD;
      if (reg_rd) begin
         if (reg_addr == OFS_TX_DMA_CTL) begin
            rdata_next[BIT_DMA_EN] = dma_bit_reg; // R03
         end else if (ser_ctl_hit(reg_addr)) begin
            rdata_next[BIT_MODE_LO+1:BIT_MODE_LO] = ctl_reg[ser_index(reg_addr)].mode; // R04
            rdata_next[BIT_DRIVE_LO+1:BIT_DRIVE_LO] = ctl_reg[ser_index(reg_addr)].drive;
            rdata_next[BIT_TX_RDY] = stat[ser_index(reg_addr)].tx_ready &&
               (ctl_reg[ser_index(reg_addr)].mode == MODE_TX); // R08
            rdata_next[BIT_RX_RDY] = stat[ser_index(reg_addr)].rx_ready &&
               (ctl_reg[ser_index(reg_addr)].mode == MODE_RX); // R05
         end else if (reg_addr == OFS_EVT_STATUS) begin
            rdata_next = status_reg;
         end else if (reg_addr == OFS_EVT_MASK) begin
            rdata_next = mask_reg;
         end
      end
   end

   // Idle drive on inactive serializers and inactive transmit slots
   always_comb begin
      logic [1:0] d;
      d = 2'h0;
      pin_out_next = '0;
      pin_oe_next = '0;
      for (int i = 0; i < NUM_SER; i++) begin
         d = idle_drive((ctl_reg[i].mode == MODE_INACTIVE) ||
                        ((ctl_reg[i].mode == MODE_TX) && tx_inactive_slot[i]), ctl_reg[i].drive); // R12
         pin_oe_next[i] = d[1];
         pin_out_next[i] = d[0];
      end
   end

   // All block registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dma_bit_reg <= RST_DMA_EN_BIT;
         ctl_reg <= {NUM_SER{RST_SER_CTL}};
         status_reg <= RST_WORD;
         mask_reg <= RST_WORD;
         rdata_reg <= RST_WORD;
         irq_reg <= 1'b0;
         dma_en_reg <= 1'b1;
         clear_prev_reg <= 1'b0;
         pin_out_reg <= '0;
         pin_oe_reg <= '0;
      end else begin
         dma_bit_reg <= dma_bit_next;
         ctl_reg <= ctl_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
         dma_en_reg <= dma_en_next;
         clear_prev_reg <= tx_serializer_clear;
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

   // Outputs
   assign reg_rdata = rdata_reg;
   assign irq = irq_reg;
   assign tx_data_dma_request_enable = dma_en_reg;
   assign serializer_mode = mode_flat;
   assign pin_idle_out = pin_out_reg;
   assign pin_idle_oe = pin_oe_reg;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   dma_enable_a: assert property (reg_wr && (reg_addr == OFS_TX_DMA_CTL) |=> // R01
      tx_data_dma_request_enable == !$past(reg_wdata[BIT_DMA_EN]))
      else $error("dma enable polarity wrong");

   dma_reserved_a: assert property (reg_rd && (reg_addr == OFS_TX_DMA_CTL) |=> // R03
      reg_rdata[31:1] == 31'h0)
      else $error("dma control reserved bits nonzero");

   ctl_reserved_a: assert property (reg_rd && ser_ctl_hit(reg_addr) |=> // R03
      reg_rdata[31:CTL_USED_W] == 26'h0)
      else $error("serializer control reserved bits nonzero");

   ctl_decode_a: assert property (reg_wr && ser_ctl_hit(reg_addr) ##1 // R04
      (reg_rd && (reg_addr == $past(reg_addr)) && !reg_wr) |=>
      reg_rdata[3:0] == $past(reg_wdata[3:0], 2))
      else $error("serializer control word not at its address");

   irq_level_a: assert property (irq == |(status_reg & mask_reg)) // R07 R11
      else $error("interrupt level does not follow unmasked status");

   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0) // R03
      else $error("read data not zero outside a read");

   dma_hold_a: assert property (!(reg_wr && (reg_addr == OFS_TX_DMA_CTL)) |=> // R01
      $stable(tx_data_dma_request_enable))
      else $error("dma enable changed without a write");

   for (genvar i = 0; i < NUM_SER; i++) begin : g_chk
      rx_zero_a: assert property ((ctl_reg[i].mode != MODE_RX) |=> !rx_buffer_ready[i]) // R05
         else $error("rx ready set outside receive mode");
      rx_set_a: assert property ((ctl_reg[i].mode == MODE_RX) && rx_word_load[i] |=> // R06
         rx_buffer_ready[i])
         else $error("rx ready not set on buffer load");
      rx_overrun_a: assert property ((ctl_reg[i].mode == MODE_RX) && slot_start && // R07
         rx_buffer_ready[i] && !rx_buf_read[i] |-> ##2 status_reg[i])
         else $error("receiver overrun not recorded");
      tx_zero_a: assert property ((ctl_reg[i].mode != MODE_TX) |=> !tx_buffer_ready[i]) // R08
         else $error("tx ready set outside transmit mode");
      tx_set_a: assert property ((ctl_reg[i].mode == MODE_TX) && clear_rise |=> // R09
         tx_buffer_ready[i])
         else $error("tx ready not set on clear rising");
      tx_hold_a: assert property (tx_buffer_ready[i] && (ctl_reg[i].mode == MODE_TX) && // R10
         tx_serializer_clear && !tx_buf_write[i] |=> tx_buffer_ready[i])
         else $error("tx ready dropped without cause");
      tx_drop_a: assert property (tx_buffer_ready[i] && (tx_buf_write[i] || !tx_serializer_clear) && // R10
         !clear_rise |=> !tx_buffer_ready[i])
         else $error("tx ready not cleared");
      tx_underrun_a: assert property ((ctl_reg[i].mode == MODE_TX) && tx_serializer_clear && // R11
         slot_start && tx_buffer_ready[i] && !tx_buf_write[i] |-> ##2 status_reg[UNDERRUN_LO+i])
         else $error("transmit underrun not recorded");
      pin_low_a: assert property ((ctl_reg[i].mode == MODE_INACTIVE) && (ctl_reg[i].drive == DRIVE_LOW) // R12
         |=> pin_idle_oe[i] && !pin_idle_out[i])
         else $error("idle pin not driven low");
      pin_tri_a: assert property ((ctl_reg[i].drive == DRIVE_TRI) || (ctl_reg[i].mode == MODE_RX) // R12
         |=> !pin_idle_oe[i])
         else $error("idle pin driven when it should float");
      rx_read_a: assert property (rx_buffer_ready[i] && rx_buf_read[i] && !rx_word_load[i] |=> // R13
         !rx_buffer_ready[i])
         else $error("rx ready not cleared by read");
      rx_hold_a: assert property (rx_buffer_ready[i] && (ctl_reg[i].mode == MODE_RX) && !rx_buf_read[i] |=> // R06
         rx_buffer_ready[i])
         else $error("rx ready dropped without a read");
      ovr_sticky_a: assert property (status_reg[i] && // R07
         !(reg_wr && (reg_addr == OFS_EVT_STATUS) && reg_wdata[i]) |=> status_reg[i])
         else $error("overrun flag lost without a clear");
      und_sticky_a: assert property (status_reg[UNDERRUN_LO+i] && // R11
         !(reg_wr && (reg_addr == OFS_EVT_STATUS) && reg_wdata[UNDERRUN_LO+i]) |=> status_reg[UNDERRUN_LO+i])
         else $error("underrun flag lost without a clear");
      pin_high_a: assert property ((ctl_reg[i].mode == MODE_INACTIVE) && (ctl_reg[i].drive == DRIVE_HIGH) // R12
         |=> pin_idle_oe[i] && pin_idle_out[i])
         else $error("idle pin not driven high");
      pin_slot_a: assert property ((ctl_reg[i].mode == MODE_TX) && (ctl_reg[i].drive == DRIVE_LOW) && // R12
         tx_inactive_slot[i] |=> pin_idle_oe[i] && !pin_idle_out[i])
         else $error("inactive slot not driven low");
      pin_active_a: assert property ((ctl_reg[i].mode == MODE_TX) && !tx_inactive_slot[i] |=> !pin_idle_oe[i]) // R12
         else $error("pin driven in an active slot");
   end

   // Main scenarios
   cov_rx_cycle_c: cover property (rx_word_load[0] ##1 rx_buffer_ready[0] ##[1:8] rx_buf_read[0]);
   cov_tx_cycle_c: cover property (clear_rise ##1 tx_buffer_ready[0] ##[1:8] tx_buf_write[0]);
   cov_overrun_c: cover property (stat[0].rx_overrun ##[1:4] irq);
   cov_underrun_c: cover property (stat[1].tx_underrun ##1 status_reg[UNDERRUN_LO+1]);
   cov_wr_rd_c: cover property (reg_wr && ser_ctl_hit(reg_addr) ##1 reg_rd);

endmodule : srs_serializer_ready_status
`default_nettype wire

// ---- tb/test_serializer_ready_status.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_serializer_ready_status
   import srs_pkg::*;
;
   // Clock, reset and register port
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 9'h000;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   // Data path side
   logic tx_serializer_clear = 1'b0;
   logic slot_start = 1'b0;
   logic [NUM_SER-1:0] rx_word_load = 16'h0000;
   logic [NUM_SER-1:0] rx_buf_read = 16'h0000;
   logic [NUM_SER-1:0] tx_buf_write = 16'h0000;
   logic [NUM_SER-1:0] tx_inactive_slot = 16'h0000;
   logic tx_data_dma_request_enable;
   logic [NUM_SER-1:0] rx_buffer_ready;
   logic [NUM_SER-1:0] tx_buffer_ready;
   logic [2*NUM_SER-1:0] serializer_mode;
   logic [NUM_SER-1:0] pin_idle_out;
   logic [NUM_SER-1:0] pin_idle_oe;
   logic irq;
   int fail_count = 0;
   int checks_done = 0;

   srs_serializer_ready_status u_dut (
      .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_serializer_clear(tx_serializer_clear), .slot_start(slot_start),
      .rx_word_load(rx_word_load), .rx_buf_read(rx_buf_read), .tx_buf_write(tx_buf_write),
      .tx_inactive_slot(tx_inactive_slot), .tx_data_dma_request_enable(tx_data_dma_request_enable),
      .rx_buffer_ready(rx_buffer_ready), .tx_buffer_ready(tx_buffer_ready),
      .serializer_mode(serializer_mode), .pin_idle_out(pin_idle_out), .pin_idle_oe(pin_idle_oe),
      .irq(irq)
   );

   // Clock at 125 MHz
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         $display("BAD %0t %s", $time, what);
         fail_count++;
      end
   endtask : chk

   // Wait edges, then step off the edge
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step

   // One write cycle
   task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask : reg_write

   // One read cycle, data taken in the following cycle
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp, what);
   endtask : rchk

   // Reset state and transmit DMA control bit
   task automatic t_reset_dma();
      chk(32'(tx_data_dma_request_enable), 32'h1, "dma enable after reset");
      chk(32'(rx_buffer_ready | tx_buffer_ready | pin_idle_oe), 32'h0, "outputs after reset");
      chk(32'(irq), 32'h0, "irq after reset");
      rchk(OFS_TX_DMA_CTL, 32'h0, "dma ctl reset");
      rchk(OFS_SER_CTL_BASE, 32'h0, "ser ctl reset");
      rchk(OFS_EVT_MASK, 32'h0, "mask reset");
      reg_write(OFS_TX_DMA_CTL, 32'hfffffffe);
      step(1);
      rchk(OFS_TX_DMA_CTL, 32'h0, "dma ctl reserved bits");
      chk(32'(tx_data_dma_request_enable), 32'h1, "dma enable kept");
      reg_write(OFS_TX_DMA_CTL, 32'h0);
      step(1);
      rchk(OFS_TX_DMA_CTL, 32'h0, "dma ctl cleared");
      chk(32'(tx_data_dma_request_enable), 32'h1, "dma enable with bit zero");
   endtask : t_reset_dma

   // Control word map, reserved bits and idle pin drive
   task automatic t_map_pins();
      logic [3:0] f;
      tx_inactive_slot <= 16'hffff;
      for (int i = 0; i < NUM_SER; i++) begin
         reg_write(OFS_SER_CTL_BASE + 9'(4 * i), 32'hffffffc0 | 32'(i));
      end
      step(2);
      for (int i = 0; i < NUM_SER; i++) begin
         f = 4'(i);
         rchk(OFS_SER_CTL_BASE + 9'(4 * i), {28'h0, f}, "ser ctl readback");
         chk(32'(serializer_mode[2*i +: 2]), 32'(f[1:0]), "mode output");
         chk(32'(pin_idle_oe[i]), 32'(f[3] & (f[1:0] <= 2'h1)), "idle enable");
         if (f[3] && f[1:0] <= 2'h1) begin
            chk(32'(pin_idle_out[i]), 32'(f[2]), "idle level");
         end
      end
      tx_inactive_slot <= 16'h0000;
      step(2);
      chk(32'(pin_idle_oe[13]), 32'h0, "active slot not driven");
      chk(32'(pin_idle_oe[12]), 32'h1, "inactive serializer driven");
      reg_write(9'h1cc, 32'hffffffff);
      rchk(9'h1cc, 32'h0, "unmapped reads zero");
      rchk(9'h182, 32'h0, "unaligned reads zero");
      for (int i = 0; i < NUM_SER; i++) begin
         reg_write(OFS_SER_CTL_BASE + 9'(4 * i), 32'h0);
         rchk(OFS_SER_CTL_BASE + 9'(4 * i), 32'h0, "ser ctl cleared");
      end
   endtask : t_map_pins

   // Receive ready, overrun and interrupt
   task automatic t_rx();
      reg_write(OFS_SER_CTL_BASE, 32'h2);
      reg_write(OFS_SER_CTL_BASE + 9'h4, 32'h1);
      rx_word_load <= 16'h0003;
      step(1);
      rx_word_load <= 16'h0000;
      step(1);
      chk(32'(rx_buffer_ready), 32'h1, "rx ready after load");
      rchk(OFS_SER_CTL_BASE, 32'h22, "rx ready bit 5");
      rchk(OFS_SER_CTL_BASE + 9'h4, 32'h1, "tx mode hides rx ready");
      slot_start <= 1'b1;
      step(1);
      slot_start <= 1'b0;
      step(3);
      rchk(OFS_EVT_STATUS, 32'h1, "overrun flagged");
      chk(32'(irq), 32'h0, "masked irq quiet");
      reg_write(OFS_EVT_MASK, 32'h1);
      step(2);
      chk(32'(irq), 32'h1, "irq on overrun");
      rx_buf_read <= 16'h0001;
      step(1);
      rx_buf_read <= 16'h0000;
      step(1);
      chk(32'(rx_buffer_ready), 32'h0, "rx ready cleared by read");
      reg_write(OFS_EVT_STATUS, 32'h1);
      step(2);
      chk(32'(irq), 32'h0, "irq cleared");
      slot_start <= 1'b1;
      step(1);
      slot_start <= 1'b0;
      step(3);
      rchk(OFS_EVT_STATUS, 32'h0, "no overrun when empty");
   endtask : t_rx

   // Transmit ready and underrun
   task automatic t_tx();
      reg_write(OFS_SER_CTL_BASE + 9'h8, 32'h2);
      tx_serializer_clear <= 1'b1;
      step(2);
      chk(32'(tx_buffer_ready), 32'h2, "tx ready on clear rise");
      rchk(OFS_SER_CTL_BASE + 9'h4, 32'h11, "tx ready bit 4");
      slot_start <= 1'b1;
      step(1);
      slot_start <= 1'b0;
      step(3);
      rchk(OFS_EVT_STATUS, 32'h00020000, "underrun flagged");
      reg_write(OFS_EVT_STATUS, 32'h00020000);
      tx_buf_write <= 16'h0002;
      step(1);
      tx_buf_write <= 16'h0000;
      step(1);
      chk(32'(tx_buffer_ready), 32'h0, "tx ready cleared by write");
      slot_start <= 1'b1;
      step(1);
      slot_start <= 1'b0;
      step(3);
      rchk(OFS_EVT_STATUS, 32'h0, "no underrun when full");
      tx_serializer_clear <= 1'b0;
      step(2);
      tx_serializer_clear <= 1'b1;
      step(2);
      chk(32'(tx_buffer_ready), 32'h2, "tx ready on second rise");
      tx_serializer_clear <= 1'b0;
      step(2);
      chk(32'(tx_buffer_ready), 32'h0, "tx ready cleared by clear low");
      tx_serializer_clear <= 1'b1;
      step(2);
      reg_write(OFS_SER_CTL_BASE + 9'h4, 32'h0);
      step(2);
      chk(32'(tx_buffer_ready), 32'h0, "tx ready cleared by mode");
   endtask : t_tx

   // Verdict and end of run
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   // Main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      step(1);
      t_reset_dma();
      t_map_pins();
      t_rx();
      t_tx();
      test_done();
   end

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      test_done();
   end
endmodule : test_serializer_ready_status
`default_nettype wire
